// file: logic/emap_pkg.sv
package emap_pkg;

	// Register addresses on the peripheral port, kept exactly as printed.
	localparam logic [23:0] ADDR_ATTR3 = 24'h0ffff6;
	localparam logic [23:0] ADDR_ATTR2 = 24'h0ffff7;
	localparam logic [23:0] ADDR_ATTR1 = 24'h0ffff8;
	localparam logic [23:0] ADDR_ATTR0 = 24'h0ffff9;
	localparam logic [23:0] ADDR_BUS_WAIT = 24'hfffffb;
	localparam logic [23:0] ADDR_CLOCK_GEN = 24'hfffffd;

	// Select codes on the core control port.
	localparam logic CTL_SEL_OPMODE = 1'h0;
	localparam logic CTL_SEL_STATUS = 1'h1;

	// Clock generator control fields.
	localparam int CLOCK_GEN_CONTROL_MF_LSB = 0;
	localparam int CLOCK_GEN_CONTROL_LD_LSB = 12;
	localparam int CLOCK_GEN_CONTROL_XTAL_LOW_BIT = 15;
	localparam int CLOCK_GEN_CONTROL_XTAL_DIS_BIT = 16;
	localparam int CLOCK_GEN_CONTROL_STOP_RUN_BIT = 17;
	localparam int CLOCK_GEN_CONTROL_PLL_EN_BIT = 18;
	localparam int CLOCK_GEN_CONTROL_CLKOUT_DIS_BIT = 19;
	localparam int CLOCK_GEN_CONTROL_PD_LSB = 20;

	// Attribute select fields.
	localparam int AAR_TYPE_LSB = 0;
	localparam int AAR_POL_BIT = 2;
	localparam int AAR_P_BIT = 3;
	localparam int AAR_X_BIT = 4;
	localparam int AAR_Y_BIT = 5;
	localparam int AAR_SWAP_BIT = 6;
	localparam int AAR_PACK_BIT = 7;
	localparam int AAR_NADD_LSB = 8;
	localparam int AAR_CMP_LSB = 12;
	localparam logic [1:0] AAR_TYPE_OFF = 2'h0;
	localparam logic [3:0] AAR_CMP_MAX = 4'hc;

	// Bus wait control fields.
	localparam int BCR_WS0_LSB = 0;
	localparam int BCR_WS1_LSB = 5;
	localparam int BCR_WS2_LSB = 10;
	localparam int BCR_WS3_LSB = 13;
	localparam int BCR_WSD_LSB = 16;
	localparam int BCR_STATUS_BIT = 21;
	localparam int BCR_LOCK_HOLD_BIT = 22;
	localparam int BCR_REQ_HOLD_BIT = 23;

	// Operating mode fields.
	localparam int OMR_MODE_LSB = 0;
	localparam int OMR_EXT_DIS_BIT = 4;
	localparam int OMR_MEM_SWITCH_BIT = 7;
	localparam int OMR_TA_SYNC_BIT = 11;
	localparam int OMR_BUS_REL_BIT = 12;
	localparam int OMR_PRIO_DIS_BIT = 14;

	// Core status fields.
	localparam int SR_SIXTEEN_BIT = 13;
	localparam int SR_CACHE_BIT = 19;

	// Values after reset.
	localparam logic [23:0] CLOCK_GEN_CONTROL_RST = 24'h000000;
	localparam logic [23:0] AAR_RST = 24'h000000;
	localparam logic [23:0] BCR_RST = 24'h000000;
	localparam logic [23:0] OMR_RST = 24'h000000;
	localparam logic [23:0] SR_RST = 24'h080000;
	localparam logic [12:0] PLL_MULT_RST = 13'h0001;
	localparam logic [11:0] PLL_DIV_RST = 12'h001;

	// Memory space codes of an access.
	localparam logic [1:0] SPACE_P = 2'h0;
	localparam logic [1:0] SPACE_X = 2'h1;
	localparam logic [1:0] SPACE_Y = 2'h2;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_WAIT = 1'b1
	} emap_state_type;

endpackage

// file: logic/emap_attr_decode.sv
`timescale 1ns/1ps
module emap_attr_decode (
	input wire logic [23:0] aar,
	input wire logic [23:0] addr,
	input wire logic [1:0] space,
	output logic hit
);

	// Builds a mask of the top n address bits, never more than the compare field holds.
	function automatic logic [23:0] top_mask(input logic [3:0] n);
		logic [3:0] k;
		k = (n > emap_pkg::AAR_CMP_MAX) ? emap_pkg::AAR_CMP_MAX : n;
		top_mask = ~(24'hffffff >> k);
	endfunction

	logic space_on;
	logic [23:0] mask;
	logic [23:0] cmp_val;

	// Each space has its own enable so one area can serve X and Y alike.
	always_comb begin
		case (space)
			emap_pkg::SPACE_P: space_on = aar[emap_pkg::AAR_P_BIT];
			emap_pkg::SPACE_X: space_on = aar[emap_pkg::AAR_X_BIT];
			emap_pkg::SPACE_Y: space_on = aar[emap_pkg::AAR_Y_BIT];
			default: space_on = 1'b0;
		endcase
	end

	// An area with no access type programmed never matches, so reset leaves all areas idle.
	assign mask = top_mask(aar[emap_pkg::AAR_NADD_LSB +: 4]);
	assign cmp_val = {aar[23:emap_pkg::AAR_CMP_LSB], 12'h000};
	assign hit = (aar[emap_pkg::AAR_TYPE_LSB +: 2] != emap_pkg::AAR_TYPE_OFF) && space_on
		&& ((addr & mask) == (cmp_val & mask));

endmodule // emap_attr_decode

// file: logic/emap_port.sv
`timescale 1ns/1ps
// How it works
// - clock control holds dividers and multiplier fields
// - clock control bits 15-19 steer crystal, PLL, clock output
// - access type in bits 0-1, one means SRAM
// - bit 2 sets attribute pin active polarity
// - bits 3-5 enable pin per P/X/Y space
// - bit 6 swaps low address byte to top
// - bit 7 enables packing for DMA accesses
// - area hits when top address bits match compare
// - pin zero is SRAM chip enable, active low
// - pin two drives SRAM top address line
// - bus control holds per-area wait counts
// - bus status bit 21, hold enables 22, 23
// - mode bits 0-3, bit 4 disables external bus
// - bit 7 memory switch, bit 11 ack sync
// - bit 12 picks bus busy release timing
// - bit 14 lets attribute pins assert together
// - status bit 13 enables sixteen-bit compatibility
// - status bit 19 enables instruction cache
// - status resets to cache enable only
module emap_port (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [23:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [23:0] REG_WDATA,
	output logic [23:0] REG_RDATA,
	input wire logic CTL_SEL,
	input wire logic CTL_WR,
	input wire logic CTL_RD,
	input wire logic [23:0] CTL_WDATA,
	output logic [23:0] CTL_RDATA,
	input wire logic ACC_REQ,
	input wire logic [23:0] ACC_ADDR,
	input wire logic [1:0] ACC_SPACE,
	input wire logic ACC_DMA,
	output logic ACC_READY,
	output logic ACC_DONE,
	output logic ACC_REFUSED,
	output logic [23:0] EXT_ADDR,
	output logic [3:0] ATTR_PINS,
	output logic [1:0] ACC_TYPE,
	output logic PACK_EN,
	output logic EXT_ACTIVE,
	output logic [12:0] PLL_MULT,
	output logic [11:0] PLL_DIV,
	output logic XTAL_LOW,
	output logic XTAL_DIS,
	output logic PLL_STOP_RUN,
	output logic PLL_EN,
	output logic CORE_CLK_OUT_DIS,
	output logic [3:0] OP_MODE,
	output logic EXT_BUS_DIS,
	output logic MEM_SWITCH,
	output logic TA_SYNC_SEL,
	output logic BUS_REL_SLOW,
	output logic ATTR_PRIO_DIS,
	output logic BUS_LOCK_HOLD,
	output logic BUS_REQ_HOLD,
	output logic SIXTEEN_BIT,
	output logic CACHE_EN
);

	logic [23:0] aar_reg [4];
	logic [23:0] clock_gen_control_reg;
	logic [23:0] bcr_reg;
	logic [23:0] omr_reg;
	logic [23:0] sr_reg;
	logic [23:0] reg_rdata_reg;
	logic [23:0] ctl_rdata_reg;
	logic [12:0] pll_mult_reg;
	logic [11:0] pll_div_reg;
	emap_pkg::emap_state_type state_reg;
	logic [4:0] count_reg;
	logic [3:0] pin_act_reg;
	logic [3:0] pin_act_next;
	logic [3:0] attr_pins_reg;
	logic [23:0] ext_addr_reg;
	logic [1:0] acc_type_reg;
	logic pack_reg;
	logic done_reg;
	logic refused_reg;
	logic refused_lat_reg;
	logic [3:0] hit;
	logic any_hit;
	logic [1:0] sel_area;
	logic acc_take;
	logic [4:0] wait_sel;
	logic [23:0] sel_aar;
	logic [23:0] bcr_view;

	// Lowest numbered area wins when more than one matches.
	function automatic logic [1:0] first_hit(input logic [3:0] h);
		if (h[0]) begin
			first_hit = 2'h0;
		end else if (h[1]) begin
			first_hit = 2'h1;
		end else if (h[2]) begin
			first_hit = 2'h2;
		end else begin
			first_hit = 2'h3;
		end
	endfunction

	// Wait count of an area, narrower fields widened to five bits.
	function automatic logic [4:0] area_wait(input logic [23:0] b, input logic [1:0] a,
		input logic any);
		if (!any) begin
			area_wait = b[emap_pkg::BCR_WSD_LSB +: 5];
		end else begin
			case (a)
				2'h0: area_wait = b[emap_pkg::BCR_WS0_LSB +: 5];
				2'h1: area_wait = b[emap_pkg::BCR_WS1_LSB +: 5];
				2'h2: area_wait = {2'h0, b[emap_pkg::BCR_WS2_LSB +: 3]};
				default: area_wait = {2'h0, b[emap_pkg::BCR_WS3_LSB +: 3]};
			endcase
		end
	endfunction

	// One comparator per attribute area.
	for (genvar i = 0; i < 4; i++) begin : g_area
		emap_attr_decode u_dec (
			.aar(aar_reg[i]),
			.addr(ACC_ADDR),
			.space(ACC_SPACE),
			.hit(hit[i])
		);
	end

	// Area selection and the request handshake.
	assign any_hit = |hit;
	assign sel_area = first_hit(hit);
	assign sel_aar = aar_reg[sel_area];
	assign wait_sel = area_wait(bcr_reg, sel_area, any_hit);
	assign ACC_READY = (state_reg == emap_pkg::ST_IDLE);
	assign acc_take = ACC_READY && ACC_REQ;

	// Without priority every matching pin asserts; with it only the first.
	always_comb begin
		pin_act_next = 4'h0;
		if (acc_take && !omr_reg[emap_pkg::OMR_EXT_DIS_BIT]) begin
			if (omr_reg[emap_pkg::OMR_PRIO_DIS_BIT]) begin
				pin_act_next = hit;
			end else if (any_hit) begin
				pin_act_next = 4'h1 << sel_area;
			end
		end else if (state_reg == emap_pkg::ST_WAIT && count_reg != 5'h00) begin
			pin_act_next = pin_act_reg;
		end
	end

	// Attribute register writes on the peripheral port.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 4; i++) begin
				aar_reg[i] <= emap_pkg::AAR_RST;
			end
		end else if (REG_WR) begin
			case (REG_ADDR)
				emap_pkg::ADDR_ATTR0: aar_reg[0] <= REG_WDATA;
				emap_pkg::ADDR_ATTR1: aar_reg[1] <= REG_WDATA;
				emap_pkg::ADDR_ATTR2: aar_reg[2] <= REG_WDATA;
				emap_pkg::ADDR_ATTR3: aar_reg[3] <= REG_WDATA;
				default: ;
			endcase
		end
	end

	// Clock and bus control writes; the bus status bit is never stored.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			clock_gen_control_reg <= emap_pkg::CLOCK_GEN_CONTROL_RST;
			bcr_reg <= emap_pkg::BCR_RST;
		end else if (REG_WR) begin
			if (REG_ADDR == emap_pkg::ADDR_CLOCK_GEN) begin
				clock_gen_control_reg <= REG_WDATA;
			end
			if (REG_ADDR == emap_pkg::ADDR_BUS_WAIT) begin
				bcr_reg <= REG_WDATA & ~(24'h000001 << emap_pkg::BCR_STATUS_BIT);
			end
		end
	end

	// Mode and status writes on the core control port.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			omr_reg <= emap_pkg::OMR_RST;
			sr_reg <= emap_pkg::SR_RST;
		end else if (CTL_WR) begin
			if (CTL_SEL == emap_pkg::CTL_SEL_OPMODE) begin
				omr_reg <= CTL_WDATA;
			end else begin
				sr_reg <= CTL_WDATA;
			end
		end
	end

	// The live status bit shows whether an external access is under way.
	assign bcr_view = bcr_reg
		| ({23'h000000, (state_reg == emap_pkg::ST_WAIT)} << emap_pkg::BCR_STATUS_BIT);

	// Read data are registered; an unmapped address reads as zero.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			reg_rdata_reg <= 24'h000000;
		end else if (REG_RD) begin
			case (REG_ADDR)
				emap_pkg::ADDR_ATTR0: reg_rdata_reg <= aar_reg[0];
				emap_pkg::ADDR_ATTR1: reg_rdata_reg <= aar_reg[1];
				emap_pkg::ADDR_ATTR2: reg_rdata_reg <= aar_reg[2];
				emap_pkg::ADDR_ATTR3: reg_rdata_reg <= aar_reg[3];
				emap_pkg::ADDR_BUS_WAIT: reg_rdata_reg <= bcr_view;
				emap_pkg::ADDR_CLOCK_GEN: reg_rdata_reg <= clock_gen_control_reg;
				default: reg_rdata_reg <= 24'h000000;
			endcase
		end
	end

	// Control port read data.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ctl_rdata_reg <= 24'h000000;
		end else if (CTL_RD) begin
			ctl_rdata_reg <= (CTL_SEL == emap_pkg::CTL_SEL_OPMODE) ? omr_reg : sr_reg;
		end
	end

	// Ratio terms for the clock generator: multiplier is field plus one, the
	// predivider is field plus one and the low-power divider a power of two.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			pll_mult_reg <= emap_pkg::PLL_MULT_RST;
			pll_div_reg <= emap_pkg::PLL_DIV_RST;
		end else begin
			pll_mult_reg <= {1'b0, clock_gen_control_reg[emap_pkg::CLOCK_GEN_CONTROL_MF_LSB +: 12]} + 13'h0001;
			pll_div_reg <= (12'({8'h00, clock_gen_control_reg[emap_pkg::CLOCK_GEN_CONTROL_PD_LSB +: 4]}) + 12'h001)
				<< clock_gen_control_reg[emap_pkg::CLOCK_GEN_CONTROL_LD_LSB +: 3];
		end
	end

	// Access sequencer: holds the access for the wait count, then finishes.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= emap_pkg::ST_IDLE;
			count_reg <= 5'h00;
			refused_lat_reg <= 1'b0;
		end else begin
			case (state_reg)
				emap_pkg::ST_IDLE: begin
					if (acc_take) begin
						state_reg <= emap_pkg::ST_WAIT;
						refused_lat_reg <= omr_reg[emap_pkg::OMR_EXT_DIS_BIT];
						count_reg <= omr_reg[emap_pkg::OMR_EXT_DIS_BIT] ? 5'h00 : wait_sel;
					end
				end
				emap_pkg::ST_WAIT: begin
					if (count_reg == 5'h00) begin
						state_reg <= emap_pkg::ST_IDLE;
					end else begin
						count_reg <= count_reg - 5'h01;
					end
				end
				default: state_reg <= emap_pkg::ST_IDLE;
			endcase
		end
	end

	// Completion pulse; a refused access still completes so the core never hangs.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			done_reg <= (state_reg == emap_pkg::ST_WAIT) && (count_reg == 5'h00);
			refused_reg <= (state_reg == emap_pkg::ST_WAIT) && (count_reg == 5'h00)
				&& refused_lat_reg;
		end
	end

	// Pins follow polarity even when idle, so a low-active chip enable rests high.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_act_reg <= 4'h0;
			attr_pins_reg <= 4'hf;
		end else begin
			pin_act_reg <= pin_act_next;
			for (int i = 0; i < 4; i++) begin
				attr_pins_reg[i] <= pin_act_next[i] ~^ aar_reg[i][emap_pkg::AAR_POL_BIT];
			end
		end
	end

	// External address, access type and packing, latched from the selected area.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ext_addr_reg <= 24'h000000;
			acc_type_reg <= emap_pkg::AAR_TYPE_OFF;
			pack_reg <= 1'b0;
		end else if (acc_take) begin
			if (any_hit && sel_aar[emap_pkg::AAR_SWAP_BIT]) begin
				ext_addr_reg <= {ACC_ADDR[7:0], ACC_ADDR[15:8], ACC_ADDR[23:16]};
			end else begin
				ext_addr_reg <= ACC_ADDR;
			end
			acc_type_reg <= any_hit ? sel_aar[emap_pkg::AAR_TYPE_LSB +: 2] : emap_pkg::AAR_TYPE_OFF;
			pack_reg <= any_hit && ACC_DMA && sel_aar[emap_pkg::AAR_PACK_BIT];
		end
	end

	// Outputs.
	assign REG_RDATA = reg_rdata_reg;
	assign CTL_RDATA = ctl_rdata_reg;
	assign ACC_DONE = done_reg;
	assign ACC_REFUSED = refused_reg;
	assign EXT_ADDR = ext_addr_reg;
	assign ATTR_PINS = attr_pins_reg;
	assign ACC_TYPE = acc_type_reg;
	assign PACK_EN = pack_reg;
	assign EXT_ACTIVE = (state_reg == emap_pkg::ST_WAIT);
	assign PLL_MULT = pll_mult_reg;
	assign PLL_DIV = pll_div_reg;
	assign XTAL_LOW = clock_gen_control_reg[emap_pkg::CLOCK_GEN_CONTROL_XTAL_LOW_BIT];
	assign XTAL_DIS = clock_gen_control_reg[emap_pkg::CLOCK_GEN_CONTROL_XTAL_DIS_BIT];
	assign PLL_STOP_RUN = clock_gen_control_reg[emap_pkg::CLOCK_GEN_CONTROL_STOP_RUN_BIT];
	assign PLL_EN = clock_gen_control_reg[emap_pkg::CLOCK_GEN_CONTROL_PLL_EN_BIT];
	assign CORE_CLK_OUT_DIS = clock_gen_control_reg[emap_pkg::CLOCK_GEN_CONTROL_CLKOUT_DIS_BIT];
	assign OP_MODE = omr_reg[emap_pkg::OMR_MODE_LSB +: 4];
	assign EXT_BUS_DIS = omr_reg[emap_pkg::OMR_EXT_DIS_BIT];
	assign MEM_SWITCH = omr_reg[emap_pkg::OMR_MEM_SWITCH_BIT];
	assign TA_SYNC_SEL = omr_reg[emap_pkg::OMR_TA_SYNC_BIT];
	assign BUS_REL_SLOW = omr_reg[emap_pkg::OMR_BUS_REL_BIT];
	assign ATTR_PRIO_DIS = omr_reg[emap_pkg::OMR_PRIO_DIS_BIT];
	assign BUS_LOCK_HOLD = bcr_reg[emap_pkg::BCR_LOCK_HOLD_BIT];
	assign BUS_REQ_HOLD = bcr_reg[emap_pkg::BCR_REQ_HOLD_BIT];
	assign SIXTEEN_BIT = sr_reg[emap_pkg::SR_SIXTEEN_BIT];
	assign CACHE_EN = sr_reg[emap_pkg::SR_CACHE_BIT];

	// Checks on the sequencer and the register effects.
	a_zero_wait_done: assert property (@(posedge MCLK) disable iff (!RST_N)
		acc_take && !EXT_BUS_DIS && wait_sel == 5'h00 |=> !ACC_DONE ##1 ACC_DONE)
		else $error("zero wait access did not finish in one cycle");
	a_one_wait_done: assert property (@(posedge MCLK) disable iff (!RST_N)
		acc_take && !EXT_BUS_DIS && wait_sel == 5'h01 |=> !ACC_DONE ##1 !ACC_DONE ##1 ACC_DONE)
		else $error("one wait access timing wrong");
	a_status_reset: assert property (@(posedge MCLK) disable iff (!RST_N)
		$rose(RST_N) |-> sr_reg == emap_pkg::SR_RST)
		else $error("status not at reset value");
	a_pll_mult_track: assert property (@(posedge MCLK) disable iff (!RST_N)
		##1 PLL_MULT == {1'b0, $past(clock_gen_control_reg[11:0])} + 13'h0001)
		else $error("multiplier does not follow clock control");
	a_pin_polarity: assert property (@(posedge MCLK) disable iff (!RST_N)
		pin_act_reg[0] && $stable(aar_reg[0]) |-> ATTR_PINS[0] == aar_reg[0][2])
		else $error("pin zero level disagrees with polarity");
	a_prio_one_pin: assert property (@(posedge MCLK) disable iff (!RST_N)
		!$past(ATTR_PRIO_DIS) |-> $onehot0(pin_act_reg))
		else $error("several pins active under priority");
	a_refused_done: assert property (@(posedge MCLK) disable iff (!RST_N)
		acc_take && EXT_BUS_DIS |=> pin_act_reg == 4'h0 ##1 (ACC_DONE && ACC_REFUSED))
		else $error("disabled bus access not refused");
	a_bus_status_read: assert property (@(posedge MCLK) disable iff (!RST_N)
		REG_RD && REG_ADDR == emap_pkg::ADDR_BUS_WAIT && EXT_ACTIVE |=> REG_RDATA[21])
		else $error("bus status bit not shown");
	a_swap_addr: assert property (@(posedge MCLK) disable iff (!RST_N)
		acc_take && any_hit && sel_aar[6] |=> EXT_ADDR[23:16] == $past(ACC_ADDR[7:0]))
		else $error("address swap not applied");
	a_cache_write: assert property (@(posedge MCLK) disable iff (!RST_N)
		CTL_WR && CTL_SEL == emap_pkg::CTL_SEL_STATUS |=> CACHE_EN == $past(CTL_WDATA[19]))
		else $error("cache enable not written");

	c_waited_access: cover property (@(posedge MCLK) disable iff (!RST_N)
		acc_take && wait_sel != 5'h00 ##[2:40] ACC_DONE);
	c_refused: cover property (@(posedge MCLK) disable iff (!RST_N) ACC_REFUSED);
	c_two_pins: cover property (@(posedge MCLK) disable iff (!RST_N)
		pin_act_reg[0] && pin_act_reg[2]);

endmodule // emap_port

// file: verification/emap_sram_model.sv
`timescale 1ns/1ps
module emap_sram_model #(
	parameter int ACCESS_NS = 12
) (
	input wire logic ce_n,
	input wire logic a15,
	input wire logic [14:0] addr,
	output logic [15:0] bank_addr
);
	logic [15:0] last_addr;

	// The bank shows the row it decodes, settled within its access budget.
	// Deselected, it shows the inverse of the last row so nobody can lean on stale data.
	always @(ce_n or a15 or addr) begin
		if (!ce_n) begin
			last_addr = {a15, addr};
			bank_addr <= #(ACCESS_NS) {a15, addr};
		end else begin
			bank_addr <= #(ACCESS_NS) ~last_addr;
		end
	end

	// Start from a known row so the first deselected value is defined.
	initial last_addr = 16'h0000;
endmodule // emap_sram_model

// file: verification/emap_port_bench.sv
`timescale 1ns/1ps
module emap_port_bench;
	logic mclk, rst_n, reg_wr, reg_rd, ctl_sel, ctl_wr, ctl_rd, acc_req, acc_dma;
	logic [23:0] reg_addr, reg_wdata, reg_rdata, ctl_wdata, ctl_rdata, acc_addr, ext_addr;
	logic [1:0] acc_space, acc_type;
	logic acc_ready, acc_done, acc_refused, pack_en, ext_active;
	logic [3:0] attr_pins, op_mode;
	logic [12:0] pll_mult;
	logic [11:0] pll_div;
	logic xtal_low, xtal_dis, pll_stop_run, pll_en, clk_dis, ext_bus_dis, mem_switch;
	logic ta_sync_sel, bus_rel_slow, prio_dis, lock_hold, req_hold, sixteen_bit, cache_en;
	logic [15:0] bank_addr;
	logic [23:0] rd;
	int bad_count, checks_done;

	emap_port emap_port_inst (.MCLK(mclk), .RST_N(rst_n), .REG_ADDR(reg_addr),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.CTL_SEL(ctl_sel), .CTL_WR(ctl_wr), .CTL_RD(ctl_rd), .CTL_WDATA(ctl_wdata),
		.CTL_RDATA(ctl_rdata), .ACC_REQ(acc_req), .ACC_ADDR(acc_addr),
		.ACC_SPACE(acc_space), .ACC_DMA(acc_dma), .ACC_READY(acc_ready),
		.ACC_DONE(acc_done), .ACC_REFUSED(acc_refused), .EXT_ADDR(ext_addr),
		.ATTR_PINS(attr_pins), .ACC_TYPE(acc_type), .PACK_EN(pack_en),
		.EXT_ACTIVE(ext_active), .PLL_MULT(pll_mult), .PLL_DIV(pll_div),
		.XTAL_LOW(xtal_low), .XTAL_DIS(xtal_dis), .PLL_STOP_RUN(pll_stop_run),
		.PLL_EN(pll_en), .CORE_CLK_OUT_DIS(clk_dis), .OP_MODE(op_mode),
		.EXT_BUS_DIS(ext_bus_dis), .MEM_SWITCH(mem_switch), .TA_SYNC_SEL(ta_sync_sel),
		.BUS_REL_SLOW(bus_rel_slow), .ATTR_PRIO_DIS(prio_dis), .BUS_LOCK_HOLD(lock_hold),
		.BUS_REQ_HOLD(req_hold), .SIXTEEN_BIT(sixteen_bit), .CACHE_EN(cache_en));

	// Bank zero enables on pin zero and takes its top line from pin two.
	emap_sram_model emap_sram_model_inst (.ce_n(attr_pins[0]), .a15(attr_pins[2]),
		.addr(ext_addr[14:0]), .bank_addr(bank_addr));

	// Free-running 20 MHz clock.
	initial mclk = 1'b0;
	always #25 mclk = ~mclk;

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		if (bad_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [23:0] addr, input logic [23:0] data);
		@(negedge mclk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask

	task automatic reg_read(input logic [23:0] addr, output logic [23:0] data);
		@(negedge mclk);
		reg_addr = addr;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		data = reg_rdata;
	endtask

	task automatic ctl_write(input logic sel, input logic [23:0] data);
		@(negedge mclk);
		ctl_sel = sel;
		ctl_wdata = data;
		ctl_wr = 1'b1;
		@(negedge mclk);
		ctl_wr = 1'b0;
	endtask

	task automatic ctl_read(input logic sel, output logic [23:0] data);
		@(negedge mclk);
		ctl_sel = sel;
		ctl_rd = 1'b1;
		@(negedge mclk);
		ctl_rd = 1'b0;
		data = ctl_rdata;
	endtask

	// One external access; pins are checked in the first wait cycle and after completion.
	task automatic access(input logic [23:0] addr, input logic [1:0] space, input logic dma,
		input logic [3:0] pins, input logic [3:0] idle, input logic [1:0] xtype,
		input logic [23:0] xaddr, input logic pack, input int waits, input logic refused);
		@(negedge mclk);
		check({23'h0, acc_ready}, 24'h1);
		acc_addr = addr;
		acc_space = space;
		acc_dma = dma;
		acc_req = 1'b1;
		@(negedge mclk);
		acc_req = 1'b0;
		reg_addr = emap_pkg::ADDR_BUS_WAIT;
		reg_rd = 1'b1;
		check({23'h0, ext_active}, 24'h1);
		check({20'h0, attr_pins}, {20'h0, pins});
		if (!refused) begin
			check(ext_addr, xaddr);
			check({22'h0, acc_type}, {22'h0, xtype});
			check({23'h0, pack_en}, {23'h0, pack});
		end
		if (!pins[0]) check({8'h0, bank_addr}, {8'h0, pins[2], xaddr[14:0]});
		repeat (waits) begin
			@(negedge mclk);
			reg_rd = 1'b0;
			check({23'h0, acc_done}, 24'h0);
		end
		@(negedge mclk);
		reg_rd = 1'b0;
		check({22'h0, acc_done, acc_refused}, {22'h0, 1'b1, refused});
		check({20'h0, attr_pins}, {20'h0, idle});
		check({23'h0, reg_rdata[21]}, 24'h1);
	endtask

	task automatic t_reset;
		ctl_read(emap_pkg::CTL_SEL_STATUS, rd);
		check(rd, 24'h080000);
		check({23'h0, cache_en}, 24'h1);
		check({11'h0, pll_mult}, 24'h1);
		check({12'h0, pll_div}, 24'h1);
		check({20'h0, attr_pins}, 24'hf);
	endtask

	task automatic t_clock;
		reg_write(emap_pkg::ADDR_CLOCK_GEN, 24'h0e0013);
		reg_read(emap_pkg::ADDR_CLOCK_GEN, rd);
		check(rd, 24'h0e0013);
		check({11'h0, pll_mult}, 24'h14);
		check({12'h0, pll_div}, 24'h1);
		check({19'h0, clk_dis, pll_en, pll_stop_run, xtal_dis, xtal_low}, 24'h1c);
		reg_write(emap_pkg::ADDR_CLOCK_GEN, 24'h21b0ff);
		// The ratio terms are registered one cycle behind the control register.
		@(negedge mclk);
		check({11'h0, pll_mult}, 24'h100);
		check({12'h0, pll_div}, 24'h18);
		check({19'h0, clk_dis, pll_en, pll_stop_run, xtal_dis, xtal_low}, 24'h03);
	endtask

	task automatic t_regs;
		reg_write(emap_pkg::ADDR_ATTR0, 24'h100931);
		reg_write(emap_pkg::ADDR_ATTR2, 24'h100925);
		reg_write(emap_pkg::ADDR_BUS_WAIT, 24'he02421);
		reg_read(emap_pkg::ADDR_ATTR0, rd);
		check(rd, 24'h100931);
		reg_read(emap_pkg::ADDR_ATTR2, rd);
		check(rd, 24'h100925);
		reg_read(emap_pkg::ADDR_BUS_WAIT, rd);
		check(rd, 24'hc02421);
		check({22'h0, lock_hold, req_hold}, 24'h3);
		reg_write(emap_pkg::ADDR_BUS_WAIT, 24'h002421);
		reg_read(24'h0ffffa, rd);
		check(rd, 24'h000000);
	endtask

	task automatic t_modes;
		ctl_write(emap_pkg::CTL_SEL_OPMODE, 24'h00589f);
		ctl_read(emap_pkg::CTL_SEL_OPMODE, rd);
		check(rd, 24'h00589f);
		check({20'h0, op_mode}, 24'hf);
		check({19'h0, prio_dis, bus_rel_slow, ta_sync_sel, mem_switch, ext_bus_dis},
			24'h1f);
		access(24'h100000, emap_pkg::SPACE_X, 1'b0, 4'hb, 4'hb, 2'h0, 24'h0, 1'b0, 0,
			1'b1);
		ctl_write(emap_pkg::CTL_SEL_STATUS, 24'h082000);
		check({22'h0, sixteen_bit, cache_en}, 24'h3);
		ctl_write(emap_pkg::CTL_SEL_STATUS, 24'h000000);
		check({22'h0, sixteen_bit, cache_en}, 24'h0);
		ctl_write(emap_pkg::CTL_SEL_STATUS, 24'h080000);
		ctl_write(emap_pkg::CTL_SEL_OPMODE, 24'h004000);
	endtask

	// X and Y share one range and split on pin two; a boundary miss takes the default count.
	task automatic t_xy;
		access(24'h100123, emap_pkg::SPACE_X, 1'b0, 4'ha, 4'hb, 2'h1, 24'h100123, 1'b0, 1,
			1'b0);
		access(24'h107fff, emap_pkg::SPACE_Y, 1'b0, 4'he, 4'hb, 2'h1, 24'h107fff, 1'b0, 1,
			1'b0);
		access(24'h108000, emap_pkg::SPACE_X, 1'b0, 4'hb, 4'hb, 2'h0, 24'h108000, 1'b0, 0,
			1'b0);
		ctl_write(emap_pkg::CTL_SEL_OPMODE, 24'h000000);
		access(24'h100001, emap_pkg::SPACE_Y, 1'b0, 4'ha, 4'hb, 2'h1, 24'h100001, 1'b0, 1,
			1'b0);
	endtask

	task automatic t_swap;
		reg_write(emap_pkg::ADDR_ATTR1, 24'h5004ce);
		access(24'h5a1234, emap_pkg::SPACE_P, 1'b1, 4'hb, 4'h9, 2'h2, 24'h34125a, 1'b1, 1,
			1'b0);
		access(24'h5a1234, emap_pkg::SPACE_P, 1'b0, 4'hb, 4'h9, 2'h2, 24'h34125a, 1'b0, 1,
			1'b0);
		access(24'h5a1234, emap_pkg::SPACE_X, 1'b1, 4'h9, 4'h9, 2'h0, 24'h5a1234, 1'b0, 0,
			1'b0);
	endtask

	// Main sequence: quiet inputs, 16 cycles of reset, then the scenarios.
	initial begin
		bad_count = 0;
		checks_done = 0;
		rst_n = 1'b0;
		{reg_wr, reg_rd, ctl_sel, ctl_wr, ctl_rd, acc_req, acc_dma} = 7'h00;
		{reg_addr, reg_wdata, ctl_wdata, acc_addr} = 96'h0;
		acc_space = 2'h3;
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		t_reset();
		t_clock();
		t_regs();
		t_modes();
		t_xy();
		t_swap();
		results();
	end

	// The scenarios need well under a thousand cycles; twenty thousand means a hang.
	initial begin
		#1000000;
		bad_count++;
		results();
	end
endmodule // emap_port_bench
